// >>> dv/asc_host_model.sv
// Host controller model driving conversion start and the serial link
`timescale 1ns/10ps
`default_nettype none
module asc_host_model
(
  input wire logic mclk,
  output logic convert_select,
  output logic serial_clk,
  output logic serial_data_in,
  input wire logic serial_data_out
);
  logic din_idle = 1'b0;
  // Clock idles low so no stray edge reads as a transfer
  initial
  begin
    convert_select = 1'b0;
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
  end
  task automatic set_idle(input logic v);
    @(posedge mclk);
    din_idle = v;
    serial_data_in <= v;
  endtask
  // Pins stay quiet around the select rise to protect the sample
  task automatic start_conv();
    repeat (4) @(posedge mclk);
    convert_select <= 1'b1;
    repeat (8) @(posedge mclk);
    convert_select <= 1'b0;
  endtask
  // Burst of n clocks; first gives the setup bit index so a write may be split
  task automatic xfer(input logic [13:0] w, input int first, input int n,
    output logic [30:0] rd);
    rd = '0;
    for (int i = first; i < first + n; i++)
    begin
      serial_data_in <= (i < 14) ? w[13-i] : din_idle;
      repeat (4) @(posedge mclk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      rd = {rd[29:0], serial_data_out};
      serial_clk <= 1'b0;
    end
    serial_data_in <= din_idle;
    repeat (8) @(posedge mclk);
  endtask
endmodule // asc_host_model
`default_nettype wire

// >>> dv/asc_port_properties.sv
// Checker of the serial setup port, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module asc_port_chk
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic convert_select,
  input wire logic serial_data_out,
  input wire logic serial_data_out_en,
  input wire logic conv_busy,
  input wire logic late_access,
  input wire logic [13:0] setup_word,
  input wire logic [2:0] channel_number,
  input wire logic config_echo_enable
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // ****
  // Properties
  // ****
  property p_busy_start;
    $rose(convert_select) && !conv_busy |-> ##[2:8] conv_busy;
  endproperty
  property p_busy_len;
    $rose(conv_busy) |-> ##100 conv_busy ##[1:20] !conv_busy;
  endproperty
  property p_setup_busy;
    conv_busy ##1 conv_busy |-> $stable(setup_word);
  endproperty
  property p_setup_idle;
    !conv_busy [*4] |-> $stable(setup_word);
  endproperty
  property p_oe_off;
    convert_select [*8] |-> !serial_data_out_en;
  endproperty
  property p_sdo_quiet;
    convert_select [*8] |-> !serial_data_out;
  endproperty
  property p_oe_on;
    !convert_select [*8] |-> serial_data_out_en;
  endproperty
  property p_late_idle;
    !conv_busy [*8] |-> !late_access;
  endproperty
  property p_chan;
    channel_number == setup_word[9:7];
  endproperty
  // Echo field is active low: the all-ones word turns echo off
  property p_echo;
    config_echo_enable == !setup_word[0];
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("no conversion after select rise");
  a_busy_len: assert property (p_busy_len)
    else $error("conversion length wrong");
  a_setup_busy: assert property (p_setup_busy)
    else $error("setup changed in conversion");
  a_setup_idle: assert property (p_setup_idle)
    else $error("setup changed while idle");
  a_oe_off: assert property (p_oe_off)
    else $error("data out enabled while deselected");
  a_sdo_quiet: assert property (p_sdo_quiet)
    else $error("data out active while deselected");
  a_oe_on: assert property (p_oe_on)
    else $error("data out not enabled while selected");
  a_late_idle: assert property (p_late_idle)
    else $error("late flag outside conversion");
  a_chan: assert property (p_chan)
    else $error("channel field mismatch");
  a_echo: assert property (p_echo)
    else $error("echo field mismatch");
  c_echo: cover property ($fell(conv_busy) && config_echo_enable);
  c_late: cover property ($rose(late_access));
  c_update: cover property ($changed(setup_word));
endmodule // asc_port_chk
bind asc_serial_port asc_port_chk chk_u
(
  .mclk(mclk), .rstn(rstn), .convert_select(convert_select),
  .serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en),
  .conv_busy(conv_busy), .late_access(late_access), .setup_word(setup_word),
  .channel_number(channel_number), .config_echo_enable(config_echo_enable)
);
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench of the serial setup port
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int LIMIT = 20000;
  localparam logic [13:0] W1 = 14'h3A92;
  localparam logic [13:0] W2 = 14'h2B40;
  localparam logic [13:0] W3 = 14'h2C84;
  localparam logic [13:0] KEEP = 14'h1555;
  logic mclk, rstn, busy_mode, convert_select, serial_clk, serial_data_in;
  logic serial_data_out, late_access;
  logic [15:0] conv_data;
  logic [13:0] setup_word;
  logic [2:0] channel_number;
  logic [2:0] pairing_sel;
  logic [2:0] ref_sel;
  logic [1:0] scan_mode;
  logic filter_sel;
  logic echo_en;
  logic [30:0] r1, r2;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  asc_serial_port dut_u (.mclk(mclk), .rstn(rstn), .convert_select(convert_select),
    .serial_clk(serial_clk), .serial_data_in(serial_data_in),
    .busy_indicate_mode(busy_mode), .conv_data(conv_data),
    .serial_data_out(serial_data_out), .serial_data_out_en(), .conv_busy(),
    .late_access(late_access), .setup_word(setup_word),
    .input_pairing_select(pairing_sel), .channel_number(channel_number),
    .filter_width_select(filter_sel), .ref_select(ref_sel),
    .channel_scan_mode(scan_mode), .config_echo_enable(echo_en));
  asc_host_model host_u (.mclk(mclk), .convert_select(convert_select),
    .serial_clk(serial_clk), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out));
  // ****
  // Tasks
  // ****
  task automatic check(input string what, input logic [30:0] exp, input logic [30:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conv(input logic [15:0] d);
    conv_data <= d;
    host_u.start_conv();
    repeat (130) @(posedge mclk);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Guards against a hung handshake
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ****
  // Sequence
  // ****
  initial
  begin
    rstn = 1'b0;
    busy_mode = 1'b0;
    conv_data = 16'h0000;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (8) @(posedge mclk);
    check("reset setup", 31'(asc_pkg::SETUP_RESET), 31'(setup_word));
    host_u.set_idle(1'b1);
    conv(16'h1111);
    conv(16'h2222);
    check("ones setup", 31'(asc_pkg::SETUP_ALL_ONES), 31'(setup_word));
    check("ones echo", 31'(1'b0), 31'(echo_en));
    host_u.set_idle(1'b0);
    $display("test power_up done");
    host_u.xfer(W1, 0, 16, r1);
    check("result", 31'(16'h2222), r1);
    check("setup before", 31'(asc_pkg::SETUP_ALL_ONES), 31'(setup_word));
    conv(16'h3333);
    check("setup after", 31'(W1), 31'(setup_word));
    check("channel", 31'(W1[9:7]), 31'(channel_number));
    check("pairing", 31'(W1[12:10]), 31'(pairing_sel));
    check("filter ref scan", 31'(W1[6:1]), 31'({filter_sel, ref_sel, scan_mode}));
    check("echo enable", 31'(!W1[0]), 31'(echo_en));
    host_u.xfer(KEEP, 0, 30, r1);
    check("result no echo", 31'({16'h3333, 14'h0000}), r1);
    conv(16'h4444);
    check("kept setup", 31'(W1), 31'(setup_word));
    $display("test write done");
    host_u.xfer(W2, 0, 16, r1);
    check("result", 31'(16'h4444), r1);
    conv(16'h5555);
    host_u.xfer(KEEP, 0, 30, r1);
    check("result echo", 31'({16'h5555, W1}), r1);
    busy_mode <= 1'b1;
    conv(16'h6666);
    host_u.xfer(KEEP, 0, 31, r1);
    check("marker result echo", {1'b1, 16'h6666, W2}, r1);
    $display("test echo done");
    busy_mode <= 1'b0;
    conv(16'h7777);
    // Second burst ends well before the safe access limit
    host_u.xfer(W3, 0, 12, r1);
    conv_data <= 16'h8888;
    host_u.start_conv();
    host_u.xfer(W3, 12, 4, r2);
    check("split result", 31'(16'h7777), 31'({r1[11:0], r2[3:0]}));
    repeat (130) @(posedge mclk);
    check("split setup", 31'(W3), 31'(setup_word));
    $display("test split done");
    host_u.start_conv();
    repeat (60) @(posedge mclk);
    host_u.xfer(KEEP, 0, 1, r1);
    check("late flag", 31'(1'b1), 31'(late_access));
    repeat (130) @(posedge mclk);
    check("late cleared", 31'(1'b0), 31'(late_access));
    $display("test late done");
    end_of_test();
  end
endmodule // testbench
`default_nettype wire

// >>> hw/asc_conv_timer.sv
// Conversion timer: busy window, safe access limit and end-of-conversion pulse
`timescale 1ns/10ps
`default_nettype none
module asc_conv_timer
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic start,
  output logic busy,
  output logic unsafe,
  output logic eoc
);
  asc_pkg::asc_conv_state_t state;
  logic [asc_pkg::TIMER_W-1:0] count;

  localparam logic [asc_pkg::TIMER_W-1:0] LAST = asc_pkg::TIMER_W'(asc_pkg::CONV_CYCLES - 1);
  localparam logic [asc_pkg::TIMER_W-1:0] LIMIT = asc_pkg::TIMER_W'(asc_pkg::DATA_CYCLES);

  // A start while converting is ignored; the running conversion completes
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= asc_pkg::ASC_IDLE;
      count <= '0;
      eoc <= 1'b0;
    end
    else
    begin
      eoc <= 1'b0;
      unique case (state)
        asc_pkg::ASC_IDLE:
        begin
          count <= '0;
          if (start)
            state <= asc_pkg::ASC_CONVERT;
        end
        asc_pkg::ASC_CONVERT:
        begin
          if (count == LAST)
          begin
            state <= asc_pkg::ASC_IDLE;
            eoc <= 1'b1;
          end
          count <= count + 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy <= 1'b0;
      unsafe <= 1'b0;
    end
    else
    begin
      busy <= (state == asc_pkg::ASC_CONVERT) && (count != LAST);
      unsafe <= (state == asc_pkg::ASC_CONVERT) && (count >= LIMIT) && (count != LAST);
    end
  end
endmodule // asc_conv_timer
`default_nettype wire

// >>> hw/asc_pkg.sv
// Constants and types shared by the serial setup port of the converter
//
// Contract
// - Device holds a 14-bit setup word steering input, channel, reference and options.
// - Rising convert_select starts a conversion, independent of serial readback timing.
// - Setup word enters MSB first on the first 14 rising serial clock edges.
// - Result leaves on first 15 falling edges, or 16 in busy indication mode.
// - With echo enabled the setup word follows the result LSB; host adds 14 edges.
// - Serial reads and writes happen only while convert_select is low.
// - Transfer around conversion n returns result n-1; its write governs n+1.
// - Written setup word takes effect at end of conversion, one conversion late.
// - Setup undefined after power-up; host runs two dummy conversions with writes.
// - Data-in held high over two conversions loads the all-ones setup word.
// - Field order bit 13 down: update, pairing, channel, filter, reference, scan, echo.
// - Update flag 0 keeps present setup; 1 overwrites it with the new word.
// - Channel bits select the input channel as a plain binary number.
package asc_pkg;
  localparam int SETUP_W = 14;
  localparam int RESULT_W = 16;
  localparam int STREAM_W = 1 + RESULT_W + SETUP_W;
  localparam int BITCNT_W = 4;
  localparam logic [BITCNT_W-1:0] SETUP_BITS = 4'hE;

  // Setup word field positions
  localparam int UPDATE_BIT = 13;
  localparam int PAIRING_MSB = 12;
  localparam int PAIRING_LSB = 10;
  localparam int CHANNEL_MSB = 9;
  localparam int CHANNEL_LSB = 7;
  localparam int FILTER_BIT = 6;
  localparam int REFSEL_MSB = 5;
  localparam int REFSEL_LSB = 3;
  localparam int SCAN_MSB = 2;
  localparam int SCAN_LSB = 1;
  localparam int ECHO_BIT = 0;

  localparam logic [SETUP_W-1:0] SETUP_RESET = 14'h0000;
  localparam logic [SETUP_W-1:0] SETUP_ALL_ONES = 14'h3FFF;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;
  localparam logic BUSY_MARKER = 1'b1;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV_TIME_NS = 2200;
  localparam int DATA_TIME_NS = 1200;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_CYCLES = DATA_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 8;

  typedef enum logic [0:0] {ASC_IDLE, ASC_CONVERT} asc_conv_state_t;
endpackage

// >>> hw/asc_serial_port.sv
// Serial setup port: setup word capture, result/echo shifter, conversion control
`timescale 1ns/10ps
`default_nettype none
module asc_serial_port
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic convert_select,
  input wire logic serial_clk,
  input wire logic serial_data_in,
  input wire logic busy_indicate_mode,
  input wire logic [15:0] conv_data,
  output logic serial_data_out,
  output logic serial_data_out_en,
  output logic conv_busy,
  output logic late_access,
  output logic [13:0] setup_word,
  output logic [2:0] input_pairing_select,
  output logic [2:0] channel_number,
  output logic filter_width_select,
  output logic [2:0] ref_select,
  output logic [1:0] channel_scan_mode,
  output logic config_echo_enable
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic cs_level;
  logic sclk_level;
  logic din_level;

  asc_sync u_sync_cs
  (
    .mclk(mclk),
    .rstn(rstn),
    .async_in(convert_select),
    .level(cs_level)
  );

  asc_sync u_sync_sclk
  (
    .mclk(mclk),
    .rstn(rstn),
    .async_in(serial_clk),
    .level(sclk_level)
  );

  asc_sync u_sync_din
  (
    .mclk(mclk),
    .rstn(rstn),
    .async_in(serial_data_in),
    .level(din_level)
  );

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  logic cs_prev;
  logic sclk_prev;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cs_prev <= 1'b1;
      sclk_prev <= 1'b0;
    end
    else
    begin
      cs_prev <= cs_level;
      sclk_prev <= sclk_level;
    end
  end

  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  // Clock edges count only while selected; edges with select high are dropped
  assign cs_rise = cs_level && !cs_prev;
  assign sclk_rise = sclk_level && !sclk_prev && !cs_level;
  assign sclk_fall = !sclk_level && sclk_prev && !cs_level;

  // ****************************************************************
  // Conversion timing
  // ****************************************************************
  logic busy_int;
  logic unsafe_int;
  logic eoc;

  asc_conv_timer u_timer
  (
    .mclk(mclk),
    .rstn(rstn),
    .start(cs_rise),
    .busy(busy_int),
    .unsafe(unsafe_int),
    .eoc(eoc)
  );

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      conv_busy <= 1'b0;
    else
      conv_busy <= busy_int;
  end

  // Flags serial clock activity past the safe limit; cleared by the next
  // end of conversion unless another late edge lands on that same cycle
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      late_access <= 1'b0;
    else if (unsafe_int && (sclk_rise || sclk_fall))
      late_access <= 1'b1;
    else if (eoc)
      late_access <= 1'b0;
  end

  // ****************************************************************
  // Setup word capture
  // ****************************************************************
  logic [asc_pkg::SETUP_W-1:0] setup_shift;
  logic [asc_pkg::BITCNT_W-1:0] wr_count;
  logic wr_done;
  logic [asc_pkg::SETUP_W-1:0] setup_pending;
  logic [asc_pkg::SETUP_W-1:0] next_shift;

  assign next_shift = {setup_shift[asc_pkg::SETUP_W-2:0], din_level};

  // Counters restart at end of conversion, not at select high, so a
  // transfer split around a conversion start continues where it paused
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      setup_shift <= asc_pkg::SETUP_RESET;
      wr_count <= '0;
    end
    else if (eoc)
    begin
      setup_shift <= asc_pkg::SETUP_RESET;
      wr_count <= '0;
    end
    else if (sclk_rise && (wr_count != asc_pkg::SETUP_BITS))
    begin
      setup_shift <= next_shift;
      wr_count <= wr_count + 1'b1;
    end
  end

  logic word_complete;
  assign word_complete = sclk_rise && (wr_count == asc_pkg::SETUP_BITS - 1'b1);

  // Pending word waits for the end of conversion
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      setup_pending <= asc_pkg::SETUP_RESET;
      wr_done <= 1'b0;
    end
    else if (word_complete)
    begin
      wr_done <= 1'b1;
      if (next_shift[asc_pkg::UPDATE_BIT])
        setup_pending <= next_shift;
      else
        setup_pending <= setup_word;
    end
    else if (eoc)
    begin
      wr_done <= 1'b0;
      // Without a completed write, data-in held high preloads all ones
      if (!wr_done && din_level)
        setup_pending <= asc_pkg::SETUP_ALL_ONES;
    end
  end

  // ****************************************************************
  // Active setup word
  // ****************************************************************
  // One-deep delay: a word written before this end of conversion governs
  // the following acquisition and conversion.
  // Echo field is active low, so the all-ones preload leaves echo off
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      setup_word <= asc_pkg::SETUP_RESET;
      config_echo_enable <= !asc_pkg::SETUP_RESET[asc_pkg::ECHO_BIT];
    end
    else if (eoc)
    begin
      setup_word <= setup_pending;
      config_echo_enable <= !setup_pending[asc_pkg::ECHO_BIT];
    end
  end

  assign input_pairing_select =
    setup_word[asc_pkg::PAIRING_MSB:asc_pkg::PAIRING_LSB];
  assign channel_number = setup_word[asc_pkg::CHANNEL_MSB:asc_pkg::CHANNEL_LSB];
  assign filter_width_select = setup_word[asc_pkg::FILTER_BIT];
  assign ref_select = setup_word[asc_pkg::REFSEL_MSB:asc_pkg::REFSEL_LSB];
  assign channel_scan_mode = setup_word[asc_pkg::SCAN_MSB:asc_pkg::SCAN_LSB];

  // ****************************************************************
  // Result and echo shifter
  // ****************************************************************
  logic [asc_pkg::STREAM_W-1:0] stream;
  logic [asc_pkg::SETUP_W-1:0] echo_word;
  logic [asc_pkg::STREAM_W-1:0] next_stream;

  // Echo belongs to the setup that produced the result being loaded
  assign echo_word = config_echo_enable ? setup_word : asc_pkg::SETUP_RESET;

  always_comb
  begin
    if (busy_indicate_mode)
      next_stream = {asc_pkg::BUSY_MARKER, conv_data, echo_word};
    else
      next_stream = {conv_data, echo_word, 1'b0};
  end

  // MSB is presented before the first falling edge, so the remaining
  // bits leave on 15 (or 16 with the marker) falling edges
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      stream <= '0;
    else if (eoc)
      stream <= next_stream;
    else if (sclk_fall)
      stream <= {stream[asc_pkg::STREAM_W-2:0], 1'b0};
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      serial_data_out <= 1'b0;
      serial_data_out_en <= 1'b0;
    end
    else
    begin
      serial_data_out <= !cs_level && stream[asc_pkg::STREAM_W-1];
      serial_data_out_en <= !cs_level;
    end
  end
endmodule // asc_serial_port
`default_nettype wire

// >>> hw/asc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module asc_sync
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic async_in,
  output logic level
);
  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Only stages two and three vote; stage one stays private to stage two
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      level <= 1'b0;
    else if (stage2 == stage3)
      level <= stage3;
  end
endmodule // asc_sync
`default_nettype wire
